// *** hdl/ddr2_guard_regs.svh ***
// Timing figures and pin codes for the DDR2 command timing guard.
// Assumes the core clock period below and a DDR clock of core clock / CK_DIV.
`ifndef DDR2_GUARD_REGS_SVH
`define DDR2_GUARD_REGS_SVH

`define CORE_PERIOD_NS 10.0
`define CK_DIV 2
`define DDR_PERIOD_NS (`CORE_PERIOD_NS * `CK_DIV)
`define NS_TO_CK(t) (int'($ceil((t) / `DDR_PERIOD_NS)))

`define ACTIVATE_SPACING_MIN_NS 7.5
`define WRITE_TO_READ_DELAY_NS 7.5
`define READ_TO_PRECHARGE_DELAY_NS 7.5
`define WRITE_RECOVERY_NS 15.0
`define ROW_PRECHARGE_NS 12.5
`define REFRESH_CYCLE_TIME_NS 195.0
`define SELF_REFRESH_EXIT_EXTRA_NS 10.0

`define COLUMN_COMMAND_SPACING_MIN_CK 2
`define CLOCK_ENABLE_PULSE_MIN_CK 3
`define SELF_REFRESH_EXIT_READ_DELAY_CK 200
`define PRECHARGE_POWERDOWN_EXIT_DELAY_CK 2
`define ACTIVE_POWERDOWN_FAST_EXIT_READ_DELAY_CK 2
`define ACTIVE_POWERDOWN_SLOW_EXIT_BASE_CK 8

`define MODE_SLOW_EXIT_BIT 12
`define AUTO_PRECHARGE_BIT 10
`define BANK_W 3
`define ADDR_W 13
`define GAP_W 8

// {cs_n, ras_n, cas_n, we_n}
`define PINS_MODE_SET 4'h0
`define PINS_REFRESH 4'h1
`define PINS_PRECHARGE 4'h2
`define PINS_ACTIVATE 4'h3
`define PINS_WRITE 4'h4
`define PINS_READ 4'h5
`define PINS_NOP 4'h7
`define PINS_DESELECT 4'hf

`endif

// *** hdl/ddr2_guard_pkg.sv ***
// Types shared by the DDR2 command timing guard.
// Assumes ddr2_guard_regs.svh for widths.
`include "ddr2_guard_regs.svh"

package ddr2_guard_pkg;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ACT = 4'h1,
    CMD_READ = 4'h2,
    CMD_WRITE = 4'h3,
    CMD_PRECHARGE = 4'h4,
    CMD_REFRESH = 4'h5,
    CMD_MODE_SET = 4'h6,
    CMD_SREF_ENTER = 4'h7,
    CMD_PD_ENTER = 4'h8,
    CMD_CKE_EXIT = 4'h9
  } cmd_e;
  typedef enum logic [3:0] {
    PWR_AWAKE = 4'h1,
    PWR_PRE_PD = 4'h2,
    PWR_ACT_PD = 4'h4,
    PWR_SREF = 4'h8
  } pwr_state_e;
  typedef logic [`GAP_W-1:0] gap_t;
endpackage

// *** hdl/ddr2_command_timing_guard.sv ***
// Host-side DDR2 command issuer that holds back each command until its spacing is met.
// Assumes one request at a time from core logic; drives the DDR clock as core_clk / 2.
//
// Overview of operation
// - write strobe starts read latency minus one
// - strobe rising edges aligned to clock edges
// - activates spaced by activate spacing minimum
// - column commands at least two clocks apart
// - auto-precharge write blocks bank activate recovery
// - read waits write-to-read after burst end
// - precharge waits read-to-precharge after read
// - each clock-enable level lasts three clocks
// - self-refresh exit: non-read waits refresh+10ns
// - self-refresh exit: read waits 200 clocks
// - precharge power-down exit: two clocks
// - fast active power-down exit: read two clocks
// - refresh cycle time spaces refresh and activate
// - mode bit twelve picks fast or slow exit
// - slow exit: read waits eight minus latency
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_guard_regs.svh"

module ddr2_command_timing_guard #(
  parameter int CAS_LATENCY = 4,
  parameter int ADDED_LATENCY = 0,
  parameter int BURST_LENGTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire ddr2_guard_pkg::cmd_e req_cmd,
  input wire logic [`BANK_W-1:0] req_bank,
  input wire logic [`ADDR_W-1:0] req_addr,
  input wire logic req_auto_pre,
  output logic req_ready,
  output logic ddr_ck,
  output logic ddr_ck_n,
  output logic ddr_cke,
  output logic ddr_cs_n,
  output logic ddr_ras_n,
  output logic ddr_cas_n,
  output logic ddr_we_n,
  output logic [`BANK_W-1:0] ddr_ba,
  output logic [`ADDR_W-1:0] ddr_addr,
  output logic dqs_out,
  output logic dqs_oe
);
  import ddr2_guard_pkg::*;

  localparam int NUM_BANKS = 1 << `BANK_W;
  localparam int READ_LATENCY = ADDED_LATENCY + CAS_LATENCY;
  localparam int WRITE_LATENCY = READ_LATENCY - 1;
  localparam int BURST_CK = BURST_LENGTH / 2;
  localparam int ACT_GAP_N = `NS_TO_CK(`ACTIVATE_SPACING_MIN_NS);
  localparam int PRECHARGE_N = `NS_TO_CK(`ROW_PRECHARGE_NS);
  localparam int WTR_N = WRITE_LATENCY + BURST_CK + `NS_TO_CK(`WRITE_TO_READ_DELAY_NS);
  localparam int WR_REC_N = WRITE_LATENCY + BURST_CK + `NS_TO_CK(`WRITE_RECOVERY_NS);
  localparam int DAL_N = WR_REC_N + PRECHARGE_N;
  localparam int RTP_CK = `NS_TO_CK(`READ_TO_PRECHARGE_DELAY_NS);
  localparam int RD_PRE_N = ADDED_LATENCY + ((RTP_CK > BURST_CK) ? RTP_CK : BURST_CK);
  localparam int RFC_N = `NS_TO_CK(`REFRESH_CYCLE_TIME_NS);
  localparam int XSNR_N = `NS_TO_CK(`REFRESH_CYCLE_TIME_NS + `SELF_REFRESH_EXIT_EXTRA_NS);
  localparam int SLOW_EXIT_N = `ACTIVE_POWERDOWN_SLOW_EXIT_BASE_CK - ADDED_LATENCY;
  localparam int PIPE_W = WRITE_LATENCY + BURST_CK;
  localparam int WR_OE_DLY = 2 * WRITE_LATENCY + 1;

  // count that lets a command pass after n ticks
  function automatic gap_t ld(input int n);
    ld = (n < 1) ? '0 : gap_t'(n - 1);
  endfunction

  function automatic gap_t dec(input gap_t x);
    dec = (x == '0) ? '0 : x - gap_t'(1);
  endfunction

  logic ck_r, ck_n_r, tick;
  logic ready_r, ok, issue;
  cmd_e pend_cmd_r;
  logic [`BANK_W-1:0] pend_bank_r;
  logic [`ADDR_W-1:0] pend_addr_r;
  logic pend_ap_r;
  logic cke_r, cs_n_r, ras_n_r, cas_n_r, we_n_r;
  logic [`BANK_W-1:0] ba_r;
  logic [`ADDR_W-1:0] addr_r;
  gap_t act_gap_r, col_gap_r, wtr_gap_r, rfc_gap_r, cke_hold_r;
  gap_t nonread_gap_r, read_gap_r;
  pwr_state_e pwr_r;
  logic slow_exit_r;
  logic [NUM_BANKS-1:0] bank_act_ok, bank_pre_ok, bank_open;
  logic [PIPE_W-1:0] pipe_r, pipe_nxt;
  logic dqs_r, dqs_oe_r, oe_nxt;

  // ck_r falls on a tick edge; pins change there and hold across the next rise
  assign tick = ck_r;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ck_r <= 1'b0;
      ck_n_r <= 1'b1;
    end
    else
    begin
      ck_r <= ~ck_r;
      ck_n_r <= ck_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ready_r <= 1'b1;
      pend_cmd_r <= CMD_NOP;
      pend_bank_r <= '0;
      pend_addr_r <= '0;
      pend_ap_r <= 1'b0;
    end
    else if (req_valid && ready_r)
    begin
      ready_r <= 1'b0;
      pend_cmd_r <= req_cmd;
      pend_bank_r <= req_bank;
      pend_addr_r <= req_addr;
      pend_ap_r <= req_auto_pre;
    end
    else if (issue)
    begin
      ready_r <= 1'b1;
    end
  end

  always_comb
  begin
    ok = 1'b0;
    unique case (pend_cmd_r)
      CMD_NOP: ok = 1'b1;
      CMD_ACT: ok = cke_r && act_gap_r == '0 && rfc_gap_r == '0
        && nonread_gap_r == '0 && bank_act_ok[pend_bank_r];
      CMD_READ: ok = cke_r && col_gap_r == '0 && wtr_gap_r == '0
        && read_gap_r == '0;
      CMD_WRITE: ok = cke_r && col_gap_r == '0 && nonread_gap_r == '0;
      CMD_PRECHARGE: ok = cke_r && nonread_gap_r == '0
        && (pend_ap_r ? &bank_pre_ok : bank_pre_ok[pend_bank_r]);
      CMD_REFRESH, CMD_MODE_SET: ok = cke_r && nonread_gap_r == '0 && rfc_gap_r == '0;
      CMD_SREF_ENTER, CMD_PD_ENTER: ok = cke_r && cke_hold_r == '0
        && nonread_gap_r == '0 && rfc_gap_r == '0;
      CMD_CKE_EXIT: ok = !cke_r && cke_hold_r == '0;
      default: ok = 1'b1;
    endcase
    issue = tick && !ready_r && ok;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= `PINS_DESELECT;
      ba_r <= '0;
      addr_r <= '0;
      cke_r <= 1'b1;
    end
    else if (tick)
    begin
      {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= `PINS_DESELECT;
      if (issue)
      begin
        ba_r <= pend_bank_r;
        addr_r <= pend_addr_r;
        unique case (pend_cmd_r)
          CMD_ACT: {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= `PINS_ACTIVATE;
          CMD_READ, CMD_WRITE, CMD_PRECHARGE:
          begin
            {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= (pend_cmd_r == CMD_READ) ? `PINS_READ :
              (pend_cmd_r == CMD_WRITE) ? `PINS_WRITE : `PINS_PRECHARGE;
            addr_r[`AUTO_PRECHARGE_BIT] <= pend_ap_r;
          end
          CMD_REFRESH: {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= `PINS_REFRESH;
          CMD_MODE_SET: {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= `PINS_MODE_SET;
          CMD_SREF_ENTER:
          begin
            {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= `PINS_REFRESH;
            cke_r <= 1'b0;
          end
          CMD_PD_ENTER:
          begin
            {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= `PINS_NOP;
            cke_r <= 1'b0;
          end
          CMD_CKE_EXIT:
          begin
            {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= `PINS_NOP;
            cke_r <= 1'b1;
          end
          default: {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= `PINS_DESELECT;
        endcase
      end
    end
  end

  // global spacing counters, one tick per DDR clock
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      act_gap_r <= '0;
      col_gap_r <= '0;
      wtr_gap_r <= '0;
      rfc_gap_r <= '0;
      cke_hold_r <= '0;
    end
    else if (tick)
    begin
      act_gap_r <= (issue && pend_cmd_r == CMD_ACT) ? ld(ACT_GAP_N) : dec(act_gap_r);
      col_gap_r <= (issue && (pend_cmd_r == CMD_READ || pend_cmd_r == CMD_WRITE)) ?
        ld(`COLUMN_COMMAND_SPACING_MIN_CK) : dec(col_gap_r);
      wtr_gap_r <= (issue && pend_cmd_r == CMD_WRITE) ? ld(WTR_N) : dec(wtr_gap_r);
      rfc_gap_r <= (issue && pend_cmd_r == CMD_REFRESH) ? ld(RFC_N) : dec(rfc_gap_r);
      cke_hold_r <= (issue && (pend_cmd_r == CMD_SREF_ENTER || pend_cmd_r == CMD_PD_ENTER
        || pend_cmd_r == CMD_CKE_EXIT)) ? ld(`CLOCK_ENABLE_PULSE_MIN_CK) : dec(cke_hold_r);
    end
  end

  // power state and exit delays
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwr_r <= PWR_AWAKE;
      slow_exit_r <= 1'b0;
      nonread_gap_r <= '0;
      read_gap_r <= '0;
    end
    else if (tick)
    begin
      nonread_gap_r <= dec(nonread_gap_r);
      read_gap_r <= dec(read_gap_r);
      if (issue && pend_cmd_r == CMD_MODE_SET && pend_bank_r == '0)
        slow_exit_r <= pend_addr_r[`MODE_SLOW_EXIT_BIT];
      if (issue && pend_cmd_r == CMD_SREF_ENTER)
        pwr_r <= PWR_SREF;
      if (issue && pend_cmd_r == CMD_PD_ENTER)
        pwr_r <= (|bank_open) ? PWR_ACT_PD : PWR_PRE_PD;
      if (issue && pend_cmd_r == CMD_CKE_EXIT)
      begin
        pwr_r <= PWR_AWAKE;
        unique case (pwr_r)
          PWR_SREF:
          begin
            nonread_gap_r <= ld(XSNR_N);
            read_gap_r <= ld(`SELF_REFRESH_EXIT_READ_DELAY_CK);
          end
          PWR_PRE_PD:
          begin
            nonread_gap_r <= ld(`PRECHARGE_POWERDOWN_EXIT_DELAY_CK);
            read_gap_r <= ld(`PRECHARGE_POWERDOWN_EXIT_DELAY_CK);
          end
          PWR_ACT_PD:
          begin
            nonread_gap_r <= ld(`PRECHARGE_POWERDOWN_EXIT_DELAY_CK);
            read_gap_r <= slow_exit_r ? ld(SLOW_EXIT_N)
              : ld(`ACTIVE_POWERDOWN_FAST_EXIT_READ_DELAY_CK);
          end
          PWR_AWAKE:
          begin
            nonread_gap_r <= '0;
            read_gap_r <= '0;
          end
        endcase
      end
    end
  end

  for (genvar gb = 0; gb < NUM_BANKS; gb++)
  begin : g_bank
    gap_t act_blk_r, pre_blk_r;
    logic open_r, hit;
    assign hit = issue && (pend_bank_r == `BANK_W'(gb)
      || (pend_cmd_r == CMD_PRECHARGE && pend_ap_r));
    assign bank_act_ok[gb] = (act_blk_r == '0);
    assign bank_pre_ok[gb] = (pre_blk_r == '0);
    assign bank_open[gb] = open_r;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        act_blk_r <= '0;
        pre_blk_r <= '0;
        open_r <= 1'b0;
      end
      else if (tick)
      begin
        act_blk_r <= dec(act_blk_r);
        pre_blk_r <= dec(pre_blk_r);
        if (hit && pend_cmd_r == CMD_ACT)
          open_r <= 1'b1;
        if (hit && pend_cmd_r == CMD_READ)
        begin
          pre_blk_r <= ld(RD_PRE_N);
          if (pend_ap_r)
          begin
            act_blk_r <= ld(RD_PRE_N + PRECHARGE_N);
            open_r <= 1'b0;
          end
        end
        if (hit && pend_cmd_r == CMD_WRITE)
        begin
          pre_blk_r <= ld(WR_REC_N);
          if (pend_ap_r)
          begin
            act_blk_r <= ld(DAL_N);
            open_r <= 1'b0;
          end
        end
        if (hit && pend_cmd_r == CMD_PRECHARGE)
        begin
          act_blk_r <= ld(PRECHARGE_N);
          open_r <= 1'b0;
        end
      end
    end
  end

  // write strobe window: one bit per tick since each write
  assign pipe_nxt = {pipe_r[PIPE_W-2:0], issue && pend_cmd_r == CMD_WRITE};
  assign oe_nxt = tick ? |pipe_nxt[PIPE_W-1 -: BURST_CK] : dqs_oe_r;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pipe_r <= '0;
      dqs_oe_r <= 1'b0;
      dqs_r <= 1'b0;
    end
    else
    begin
      if (tick)
        pipe_r <= pipe_nxt;
      dqs_oe_r <= oe_nxt;
      dqs_r <= oe_nxt & ~ck_r;
    end
  end

  assign req_ready = ready_r;
  assign ddr_ck = ck_r;
  assign ddr_ck_n = ck_n_r;
  assign ddr_cke = cke_r;
  assign ddr_cs_n = cs_n_r;
  assign ddr_ras_n = ras_n_r;
  assign ddr_cas_n = cas_n_r;
  assign ddr_we_n = we_n_r;
  assign ddr_ba = ba_r;
  assign ddr_addr = addr_r;
  assign dqs_out = dqs_r;
  assign dqs_oe = dqs_oe_r;

  // ticks since each event, saturating; read only by the checks below
  gap_t since_act_r, since_col_r, since_wr_r, since_cke_r, since_sref_r;
  logic act_ev, col_ev, wr_ev, cke_ev, sref_ev;
  assign act_ev = issue && pend_cmd_r == CMD_ACT;
  assign wr_ev = issue && pend_cmd_r == CMD_WRITE;
  assign col_ev = wr_ev || (issue && pend_cmd_r == CMD_READ);
  assign cke_ev = issue && (pend_cmd_r == CMD_SREF_ENTER || pend_cmd_r == CMD_PD_ENTER
    || pend_cmd_r == CMD_CKE_EXIT);
  assign sref_ev = issue && pend_cmd_r == CMD_CKE_EXIT && pwr_r == PWR_SREF;

  function automatic gap_t up(input logic ev, input gap_t x);
    up = ev ? gap_t'(1) : ((&x) ? x : x + gap_t'(1));
  endfunction

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {since_act_r, since_col_r, since_wr_r} <= {3{gap_t'(8'hff)}};
      {since_cke_r, since_sref_r} <= {2{gap_t'(8'hff)}};
    end
    else if (tick)
    begin
      since_act_r <= up(act_ev, since_act_r);
      since_col_r <= up(col_ev, since_col_r);
      since_wr_r <= up(wr_ev, since_wr_r);
      since_cke_r <= up(cke_ev, since_cke_r);
      since_sref_r <= up(sref_ev, since_sref_r);
    end
  end

  sequence s_write_issued;
    wr_ev;
  endsequence

  sequence s_strobe_started;
    ##WR_OE_DLY dqs_oe_r;
  endsequence

  a_write_latency: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_write_issued |-> s_strobe_started) else $error("write strobe window late");
  a_strobe_align: assert property (@(posedge core_clk) disable iff (!rst_b)
    dqs_oe_r |-> dqs_r == ck_r) else $error("write strobe off its clock edge");
  a_act_spacing: assert property (@(posedge core_clk) disable iff (!rst_b)
    act_ev |-> since_act_r >= gap_t'(ACT_GAP_N)) else $error("activates too close");
  a_col_spacing: assert property (@(posedge core_clk) disable iff (!rst_b)
    col_ev |-> since_col_r >= gap_t'(`COLUMN_COMMAND_SPACING_MIN_CK))
    else $error("column commands too close");
  a_wtr_gap: assert property (@(posedge core_clk) disable iff (!rst_b)
    (issue && pend_cmd_r == CMD_READ) |-> since_wr_r >= gap_t'(WTR_N))
    else $error("read too soon after write");
  a_cke_width: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(cke_r) |-> $past(since_cke_r, 1) >= gap_t'(`CLOCK_ENABLE_PULSE_MIN_CK)
      || $past(since_cke_r, 1) == gap_t'(8'hff)) else $error("clock enable pulse too short");
  a_sref_nonread: assert property (@(posedge core_clk) disable iff (!rst_b)
    (issue && pend_cmd_r != CMD_READ && pend_cmd_r != CMD_NOP) |->
      since_sref_r >= gap_t'(XSNR_N)) else $error("command too soon after self refresh");
  a_sref_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    (issue && pend_cmd_r == CMD_READ) |->
      since_sref_r >= gap_t'(`SELF_REFRESH_EXIT_READ_DELAY_CK))
    else $error("read too soon after self refresh");
endmodule // ddr2_command_timing_guard

`default_nettype wire

// *** verification/ddr2_device_model.sv ***
// DDR2 device stand-in: decodes the guard's commands and counts spacing faults.
// Assumes the guard's pins and the core clock that paces its DDR clock.
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_guard_regs.svh"

module ddr2_device_model #(
  parameter int WRITE_LATENCY = 3,
  parameter int ADDED_LATENCY = 0,
  parameter int BL = 4,
  parameter real CK_NS = 20.0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ddr_ck,
  input wire logic ddr_cke,
  input wire logic [3:0] pins,
  input wire logic [`BANK_W-1:0] ba,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic dqs_out,
  output int viol
);
  localparam int ACT = 0, COL = 1, WR = 2, RD = 3, REF = 4, CKE = 5, SX = 6, PX = 7, AX = 8;
  int ck, last_rise;
  int t [17];
  int wq [$];
  logic prev_ck, prev_dqs, prev_cke, slow, sref;
  logic [7:0] open;

  function automatic int cyc(real ns);
    return int'($ceil(ns / CK_NS));
  endfunction

  // commands and levels are judged at the DDR clock rising edges only
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      foreach (t[i]) t[i] = -999;
      ck = 0;
      viol = 0;
      {prev_ck, prev_dqs, slow, sref} = '0;
      last_rise = -999;
      wq.delete();
      prev_cke = 1;
      open = '0;
    end
    else
    begin
      if (ddr_ck && !prev_ck)
      begin
        ck++;
        if (ddr_cke !== prev_cke)
        begin
          if (ck - t[CKE] < 3) viol++;
          t[CKE] = ck;
          if (!ddr_cke) sref = (pins == 4'h1);
          else if (sref) t[SX] = ck;
          else if (|open) t[AX] = ck;
          else t[PX] = ck;
        end
        prev_cke = ddr_cke;
        // each write owes one strobe burst starting write latency clocks after it
        if (wq.size() > 0 && wq[0] < ck)
        begin
          viol++;
          wq.delete(0);
        end
        if (dqs_out && !prev_dqs)
        begin
          if (wq.size() > 0 && wq[0] == ck) wq.delete(0);
          else if (ck != last_rise + 1) viol++;
          last_rise = ck;
        end
        if (!pins[3] && pins != 4'h7)
        begin
          if (pins == 4'h5)
          begin
            if (ck - t[SX] < 200 || ck - t[PX] < 2) viol++;
            if (ck - t[AX] < (slow ? 8 - ADDED_LATENCY : 2)) viol++;
            if (ck - t[COL] < 2 || ck - t[WR] < WRITE_LATENCY + BL / 2 + cyc(7.5))
              viol++;
            t[COL] = ck;
            t[RD] = ck;
            if (addr[10]) open[ba] = 0;
          end
          else
          begin
            if (ck - t[SX] < cyc(195.0 + 10.0) || ck - t[PX] < 2) viol++;
            case (pins)
              4'h3:
              begin
                if (ck - t[ACT] < cyc(7.5) || ck - t[REF] < cyc(195.0)) viol++;
                if (ck - t[9 + ba] < WRITE_LATENCY + BL / 2 + cyc(15.0) + cyc(12.5))
                  viol++;
                t[ACT] = ck;
                open[ba] = 1;
              end
              4'h4:
              begin
                if (ck - t[COL] < 2) viol++;
                t[COL] = ck;
                t[WR] = ck;
                wq.push_back(ck + WRITE_LATENCY);
                if (addr[10]) t[9 + ba] = ck;
                if (addr[10]) open[ba] = 0;
              end
              4'h2:
              begin
                if (ck - t[RD] < ADDED_LATENCY + cyc(7.5)) viol++;
                if (addr[10]) open = '0;
                else open[ba] = 0;
              end
              4'h1, 4'h0:
              begin
                if (ck - t[REF] < cyc(195.0)) viol++;
                if (pins == 4'h1) t[REF] = ck;
                else if (ba == 0) slow = addr[12];
              end
              default: ;
            endcase
          end
        end
      end
      prev_ck = ddr_ck;
      prev_dqs = dqs_out;
    end
  end
endmodule // ddr2_device_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the DDR2 command timing guard.
// Assumes default guard latencies and the device stand-in on its pins.
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_guard_regs.svh"

module tb_top;
  import ddr2_guard_pkg::*;
  typedef struct {logic [3:0] pins; logic [2:0] ba; logic [12:0] addr;} exp_s;
  typedef struct {cmd_e c; logic [2:0] b; logic [12:0] a; logic ap;} step_s;
  logic core_clk = 0;
  logic rst_b = 0;
  logic req_valid = 0;
  cmd_e req_cmd = CMD_NOP;
  logic [`BANK_W-1:0] req_bank = '0;
  logic [`ADDR_W-1:0] req_addr = '0;
  logic req_auto_pre = 0;
  logic req_ready, ddr_ck, ddr_ck_n, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n;
  logic [`BANK_W-1:0] ddr_ba;
  logic [`ADDR_W-1:0] ddr_addr;
  logic dqs_out, dqs_oe;
  int failures = 0;
  int checks = 0;
  int viol;
  int seed = 32'hd006_9d3b;
  int r;
  logic cke_exp = 1;
  exp_s q[$];
  exp_s e;
  cmd_e pool [6] = '{CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRECHARGE, CMD_REFRESH, CMD_NOP};
  step_s steps [27] = '{
    '{CMD_ACT, 3, 5, 0}, '{CMD_WRITE, 3, 8, 0}, '{CMD_READ, 3, 8, 0}, '{CMD_PRECHARGE, 3, 0, 0},
    '{CMD_ACT, 3, 6, 0}, '{CMD_WRITE, 3, 4, 1}, '{CMD_ACT, 3, 7, 0},
    '{CMD_MODE_SET, 0, 13'h0000, 0}, '{CMD_PD_ENTER, 0, 0, 0}, '{CMD_CKE_EXIT, 0, 0, 0},
    '{CMD_READ, 3, 0, 0}, '{CMD_MODE_SET, 0, 13'h1000, 0}, '{CMD_PD_ENTER, 0, 0, 0},
    '{CMD_CKE_EXIT, 0, 0, 0}, '{CMD_READ, 3, 4, 0}, '{CMD_PRECHARGE, 0, 0, 1},
    '{CMD_PD_ENTER, 0, 0, 0}, '{CMD_CKE_EXIT, 0, 0, 0}, '{CMD_ACT, 1, 9, 0},
    '{CMD_PRECHARGE, 0, 0, 1}, '{CMD_REFRESH, 0, 0, 0}, '{CMD_REFRESH, 0, 0, 0},
    '{CMD_SREF_ENTER, 0, 0, 0}, '{CMD_CKE_EXIT, 0, 0, 0}, '{CMD_ACT, 2, 3, 0},
    '{CMD_READ, 2, 0, 0}, '{CMD_PRECHARGE, 0, 0, 1}};

  ddr2_command_timing_guard i_dut (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_auto_pre(req_auto_pre),
    .req_ready(req_ready), .ddr_ck(ddr_ck), .ddr_ck_n(ddr_ck_n), .ddr_cke(ddr_cke),
    .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n),
    .ddr_ba(ddr_ba), .ddr_addr(ddr_addr), .dqs_out(dqs_out), .dqs_oe(dqs_oe));

  ddr2_device_model i_dev (.core_clk(core_clk), .rst_b(rst_b), .ddr_ck(ddr_ck),
    .ddr_cke(ddr_cke), .pins({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n}), .ba(ddr_ba),
    .addr(ddr_addr), .dqs_out(dqs_out), .viol(viol));

  always #5 core_clk = ~core_clk;

  task check(logic [31:0] seen, logic [31:0] expv);
  begin
    checks++;
    if (seen !== expv)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, expv);
    end
  end
  endtask

  task test_done();
  begin
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  function automatic logic [3:0] pins_of(cmd_e c);
    case (c)
      CMD_ACT: return 4'h3;
      CMD_READ: return 4'h5;
      CMD_WRITE: return 4'h4;
      CMD_PRECHARGE: return 4'h2;
      CMD_REFRESH, CMD_SREF_ENTER: return 4'h1;
      CMD_MODE_SET: return 4'h0;
      default: return 4'hf;
    endcase
  endfunction

  // one request, held for one clock, then wait for the guard to issue it
  task send(cmd_e c, logic [2:0] b, logic [12:0] a, logic ap);
    int n;
    logic [12:0] ea;
  begin
    n = 0;
    ea = a;
    if (c inside {CMD_READ, CMD_WRITE, CMD_PRECHARGE}) ea[10] = ap;
    if (pins_of(c) != 4'hf) q.push_back('{pins_of(c), b, ea});
    if (c inside {CMD_PD_ENTER, CMD_SREF_ENTER}) cke_exp = 0;
    if (c == CMD_CKE_EXIT) cke_exp = 1;
    @(posedge core_clk);
    req_valid <= 1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    req_auto_pre <= ap;
    @(posedge core_clk);
    req_valid <= 0;
    #1;
    while (req_ready !== 1'b1 && n < 4000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(n < 4000, 1);
    check(ddr_cke, cke_exp);
  end
  endtask

  // every issued command except the NOP-coded power-down entry and clock-enable exit is matched against the expected queue
  always @(negedge ddr_cs_n)
  begin
    #1;
    if ({ddr_ras_n, ddr_cas_n, ddr_we_n} != 3'b111)
    begin
      if (q.size() == 0)
        check(0, 1);
      else
      begin
        e = q.pop_front();
        check({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n}, e.pins);
        check(ddr_ba, e.ba);
        check(ddr_addr, e.addr);
        check(ddr_ck_n, !ddr_ck);
      end
    end
  end

  initial
  begin
    #200_000;
    failures++;
    test_done();
  end

  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1;
    for (int i = 0; i < 40; i++)
    begin
      r = $random(seed);
      send(pool[r[7:0] % 6], r[10:8], r[23:11], r[24]);
    end
    send(cmd_e'(4'hc), 0, 0, 0);
    foreach (steps[i]) send(steps[i].c, steps[i].b, steps[i].a, steps[i].ap);
    repeat (20) @(posedge core_clk);
    check(viol, 0);
    check(q.size(), 0);
    @(posedge core_clk);
    rst_b <= 0;
    @(posedge core_clk);
    #1;
    check({req_ready, ddr_cke, ddr_cs_n, dqs_oe}, 4'he);
    @(posedge core_clk);
    rst_b <= 1;
    send(CMD_ACT, 4, 1, 0);
    repeat (4) @(posedge core_clk);
    check(viol, 0);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
